// ===== bst_ctl_model.sv
// External scan controller model driving the serial test link
`timescale 1ns/1ps

module bst_ctl_model
(
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  logic tdo_last = 1'b0;

  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One link clock; stands still low between calls
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #16;
    tdo = tdo_oe_i ? tdo_i : ~tdo_last;
    if (tdo_oe_i)
      tdo_last = tdo_i;
    tck_o = 1'b1;
    #16;
    tck_o = 1'b0;
  endtask

  // From idle: shift n bits through data or instruction path, back to idle
  task automatic scan(input logic ir, input logic [39:0] din, input int n,
                      output logic [39:0] dout);
    logic t;
    dout = '0;
    tick(1'b1, 1'b0, t);
    if (ir)
      tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
    tick(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], t);
      dout[i] = t;
    end
    tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
  endtask
endmodule

// ===== bst_pkg.sv
// Constants, types and state codes of the boundary scan test port
package bst_pkg;

  localparam int unsigned N_PLAIN   = 8;
  localparam int unsigned N_GCK     = 4;
  localparam int unsigned N_PIN     = N_PLAIN + N_GCK;
  localparam int unsigned GRP_PLAIN = 3;
  localparam int unsigned GRP_GCK   = 4;
  localparam int unsigned BSR_LEN   = GRP_PLAIN * N_PLAIN + GRP_GCK * N_GCK;
  localparam int unsigned IR_LEN    = 10;
  localparam int unsigned WORD_LEN  = 32;

  // Cell offsets inside one pin group, TDO end first
  localparam int unsigned CELL_TS  = 0;
  localparam int unsigned CELL_OUT = 1;
  localparam int unsigned CELL_IN  = 2;
  localparam int unsigned CELL_CLK = 3;

  typedef logic [IR_LEN-1:0]   bst_ir_t;
  typedef logic [WORD_LEN-1:0] bst_word_t;

  localparam bst_ir_t IR_EXTEST   = 10'h000;
  localparam bst_ir_t IR_SAMPLE   = 10'h001;
  localparam bst_ir_t IR_USERCODE = 10'h3fd;
  localparam bst_ir_t IR_IDCODE   = 10'h3fe;
  localparam bst_ir_t IR_BYPASS   = 10'h3ff;
  localparam bst_ir_t IR_CAPTURE  = 10'h001;

  // Identification value is arbitrary
  localparam bst_word_t ID_CODE_DEF   = 32'h0000_1001;
  localparam bst_word_t USER_CODE_DEF = 32'h0000_0000;
  localparam logic      BYPASS_CAP    = 1'b0;

  typedef enum logic [3:0] {
    TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SH_DR  = 4'h6, TAP_EX1_DR = 4'h7, TAP_PA_DR  = 4'h5, TAP_EX2_DR = 4'h4,
    TAP_UP_DR  = 4'hc, TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SH_IR  = 4'he,
    TAP_EX1_IR = 4'ha, TAP_PA_IR  = 4'hb, TAP_EX2_IR = 4'h9, TAP_UP_IR  = 4'h8
  } bst_tap_e;

  typedef struct packed {
    logic [N_PIN-1:0] oe;
    logic [N_PIN-1:0] dat;
  } bst_drv_s;

  typedef struct packed {
    logic [N_PIN-1:0] dat;
    logic [N_GCK-1:0] gclk;
  } bst_rx_s;

endpackage

// ===== bst_tap.sv
// Boundary scan test access port with boundary, id, user and bypass registers
`timescale 1ns/1ps

module bst_tap
  import bst_pkg::*;
#(
  parameter bst_pkg::bst_word_t ID_CODE   = bst_pkg::ID_CODE_DEF,
  parameter bst_pkg::bst_word_t USER_CODE = bst_pkg::USER_CODE_DEF
)
(
  input  wire logic                     mclk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     tck_i,
  input  wire logic                     tms_i,
  input  wire logic                     tdi_i,
  output logic                          tdo_o,
  output logic                          tdo_oe_o,
  input  wire logic [bst_pkg::N_PIN-1:0] pad_i,
  input  wire bst_pkg::bst_drv_s        core_drv_i,
  output bst_pkg::bst_drv_s             pad_drv_o,
  output bst_pkg::bst_rx_s              core_rx_o
);

  import bst_pkg::*;

  // --------------------------------------------------------------------
  // State of the three clock regions
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [N_PIN-1:0]   s1;
    logic [N_PIN-1:0]   s2;
    logic [N_PIN-1:0]   s3;
    logic [N_PIN-1:0]   filt;
    logic               t1;
    logic               t2;
    logic               t3;
    logic               act;
    logic [BSR_LEN-1:0] frc;
    bst_rx_s            core_rx;
    bst_drv_s           pad;
  } bst_mclk_s;

  typedef struct packed {
    logic [2:0]         rs;
    logic               rf;
    bst_tap_e           st;
    bst_ir_t            ir;
    bst_ir_t            irs;
    logic [BSR_LEN-1:0] dr;
    logic [BSR_LEN-1:0] upd;
    logic               act;
    logic               tgl;
    logic [BSR_LEN-1:0] c1;
    logic [BSR_LEN-1:0] c2;
    logic [BSR_LEN-1:0] c3;
    logic [BSR_LEN-1:0] cf;
  } bst_tck_s;

  typedef struct packed {
    logic tdo;
    logic oe;
  } bst_neg_s;

  bst_mclk_s          m_q;
  bst_mclk_s          m_d;
  bst_tck_s           t_q;
  bst_tck_s           t_d;
  bst_neg_s           n_q;
  bst_neg_s           n_d;
  logic [BSR_LEN-1:0] cap_raw;
  logic [N_PIN-1:0]   frc_ts;
  logic [N_PIN-1:0]   frc_out;
  logic [N_PIN-1:0]   frc_in;
  logic [N_GCK-1:0]   frc_clk;
  logic               in_shift;

  // --------------------------------------------------------------------
  // Boundary chain layout per pin
  // --------------------------------------------------------------------
  for (genvar p = 0; p < N_PIN; p++)
  begin : g_pin
    localparam int unsigned B = (p < N_PLAIN) ? GRP_PLAIN * p
                              : GRP_PLAIN * N_PLAIN + GRP_GCK * (p - N_PLAIN);
    assign frc_ts[p]              = m_q.frc[B + CELL_TS];
    assign frc_out[p]             = m_q.frc[B + CELL_OUT];
    assign frc_in[p]              = m_q.frc[B + CELL_IN];
    assign cap_raw[B + CELL_TS]   = core_drv_i.oe[p];
    assign cap_raw[B + CELL_OUT]  = core_drv_i.dat[p];
    assign cap_raw[B + CELL_IN]   = m_q.filt[p];
    if (p >= N_PLAIN)
    begin : g_gck
      assign frc_clk[p - N_PLAIN]  = m_q.frc[B + CELL_CLK];
      assign cap_raw[B + CELL_CLK] = m_q.filt[p];
    end
  end

  // --------------------------------------------------------------------
  // System clock side: pad filter, force word pickup, pin muxes
  // --------------------------------------------------------------------
  always_comb
  begin
    m_d      = m_q;
    m_d.s1   = pad_i;
    m_d.s2   = m_q.s1;
    m_d.s3   = m_q.s2;
    m_d.filt = ((m_q.s2 ~^ m_q.s3) & m_q.s3) | ((m_q.s2 ^ m_q.s3) & m_q.filt);
    m_d.t1   = t_q.tgl;
    m_d.t2   = m_q.t1;
    m_d.t3   = m_q.t2;
    // Word is stable in the test clock side while the toggle travels
    if (m_q.t2 ^ m_q.t3)
    begin
      m_d.act = t_q.act;
      m_d.frc = t_q.upd;
    end
    m_d.core_rx.dat  = m_q.act ? frc_in : m_q.filt;
    m_d.core_rx.gclk = m_q.act ? frc_clk : m_q.filt[N_PIN-1:N_PLAIN];
    m_d.pad.dat      = m_q.act ? frc_out : core_drv_i.dat;
    m_d.pad.oe       = m_q.act ? frc_ts : core_drv_i.oe;
    if (!rst_n_i)
    begin
      m_d = '0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    m_q <= m_d;
  end

  assign pad_drv_o = m_q.pad;
  assign core_rx_o = m_q.core_rx;

  // --------------------------------------------------------------------
  // Test clock side: controller, instruction and data registers
  // --------------------------------------------------------------------
  always_comb
  begin
    t_d    = t_q;
    // Reset and capture bits cross in three stages, taken once stages two and three agree
    t_d.rs = {t_q.rs[1:0], rst_n_i};
    t_d.rf = (t_q.rs[1] ~^ t_q.rs[2]) ? t_q.rs[2] : t_q.rf;
    t_d.c1 = cap_raw;
    t_d.c2 = t_q.c1;
    t_d.c3 = t_q.c2;
    t_d.cf = ((t_q.c2 ~^ t_q.c3) & t_q.c3) | ((t_q.c2 ^ t_q.c3) & t_q.cf);
    unique case (t_q.st)
      TAP_RESET:  t_d.st = tms_i ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   t_d.st = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: t_d.st = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: t_d.st = tms_i ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  t_d.st = tms_i ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: t_d.st = tms_i ? TAP_UP_DR  : TAP_PA_DR;
      TAP_PA_DR:  t_d.st = tms_i ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: t_d.st = tms_i ? TAP_UP_DR  : TAP_SH_DR;
      TAP_UP_DR:  t_d.st = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: t_d.st = tms_i ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: t_d.st = tms_i ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  t_d.st = tms_i ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: t_d.st = tms_i ? TAP_UP_IR  : TAP_PA_IR;
      TAP_PA_IR:  t_d.st = tms_i ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: t_d.st = tms_i ? TAP_UP_IR  : TAP_SH_IR;
      TAP_UP_IR:  t_d.st = tms_i ? TAP_SEL_DR : TAP_IDLE;
    endcase

    if (t_q.st == TAP_CAP_IR)
    begin
      t_d.irs = IR_CAPTURE;
    end
    if (t_q.st == TAP_SH_IR)
    begin
      t_d.irs = {tdi_i, t_q.irs[IR_LEN-1:1]};
    end
    if (t_q.st == TAP_UP_IR)
    begin
      t_d.ir  = t_q.irs;
      t_d.act = (t_q.irs == IR_EXTEST);
    end

    if (t_q.st == TAP_CAP_DR)
    begin
      if (t_q.ir == IR_EXTEST || t_q.ir == IR_SAMPLE)
        t_d.dr = t_q.cf;
      else if (t_q.ir == IR_USERCODE)
        t_d.dr = {{(BSR_LEN-WORD_LEN){1'b0}}, USER_CODE};
      else if (t_q.ir == IR_IDCODE)
        t_d.dr = {{(BSR_LEN-WORD_LEN){1'b0}}, ID_CODE};
      else
        t_d.dr = {{(BSR_LEN-1){1'b0}}, BYPASS_CAP};
    end
    if (t_q.st == TAP_SH_DR)
    begin
      if (t_q.ir == IR_EXTEST || t_q.ir == IR_SAMPLE)
        t_d.dr = {tdi_i, t_q.dr[BSR_LEN-1:1]};
      else if (t_q.ir == IR_USERCODE || t_q.ir == IR_IDCODE)
        t_d.dr = {{(BSR_LEN-WORD_LEN){1'b0}}, tdi_i, t_q.dr[WORD_LEN-1:1]};
      else
        t_d.dr = {{(BSR_LEN-1){1'b0}}, tdi_i};
    end
    if (t_q.st == TAP_UP_DR && t_q.ir == IR_EXTEST)
    begin
      t_d.upd = t_q.dr;
    end

    if (t_d.st == TAP_RESET)
    begin
      t_d.ir  = IR_IDCODE;
      t_d.act = 1'b0;
    end
    // Any change of the force word is announced to the system clock
    if (t_d.act != t_q.act || t_d.upd != t_q.upd)
    begin
      t_d.tgl = ~t_q.tgl;
    end

    if (!t_q.rf)
    begin
      t_d    = '0;
      t_d.ir = IR_IDCODE;
      t_d.rs = {t_q.rs[1:0], rst_n_i};
      t_d.rf = t_q.rs[2] & t_q.rs[1];
    end
  end

  always_ff @(posedge tck_i)
  begin
    t_q <= t_d;
  end

  // --------------------------------------------------------------------
  // Serial output on the falling test clock edge
  // --------------------------------------------------------------------
  assign in_shift = (t_q.st == TAP_SH_DR) || (t_q.st == TAP_SH_IR);

  always_comb
  begin
    n_d.oe  = in_shift;
    n_d.tdo = (t_q.st == TAP_SH_IR) ? t_q.irs[0] : t_q.dr[0];
    if (!t_q.rf)
    begin
      n_d = '0;
    end
  end

  always_ff @(negedge tck_i)
  begin
    n_q <= n_d;
  end

  assign tdo_o    = n_q.tdo;
  assign tdo_oe_o = n_q.oe;

  // --------------------------------------------------------------------
  // Checks on the test clock side
  // --------------------------------------------------------------------
  default clocking cb @(posedge tck_i);
  endclocking
  default disable iff (!t_q.rf);

  a_tlr_five_ones: assert property (tms_i [*5] |=> t_q.st == TAP_RESET)
    else $error("five mode ones did not reach reset");
  a_reset_loads_id: assert property (t_q.st == TAP_RESET
    |-> t_q.ir == IR_IDCODE && !t_q.act)
    else $error("reset state without id instruction");
  a_ir_shift_in: assert property (t_q.st == TAP_SH_IR
    |=> t_q.irs[IR_LEN-1] == $past(tdi_i))
    else $error("instruction shift lost data in");
  a_bsr_shift_in: assert property (t_q.st == TAP_SH_DR && t_q.ir == IR_SAMPLE
    |=> t_q.dr[BSR_LEN-1] == $past(tdi_i))
    else $error("boundary shift lost data in");
  a_tdo_lsb_out: assert property (t_q.st == TAP_SH_DR |-> tdo_oe_o && tdo_o == t_q.dr[0])
    else $error("data out not the low bit");
  a_tdo_idle_off: assert property (!in_shift |-> !tdo_oe_o)
    else $error("data out driven outside shift");
  a_bypass_zero: assert property (t_q.st == TAP_CAP_DR && t_q.ir == IR_BYPASS
    |=> t_q.dr[0] == BYPASS_CAP)
    else $error("bypass did not capture zero");
  a_idcode_cap: assert property (t_q.st == TAP_CAP_DR && t_q.ir == IR_IDCODE
    |=> t_q.dr[WORD_LEN-1:0] == ID_CODE)
    else $error("id word not captured");
  a_usercode_cap: assert property (t_q.st == TAP_CAP_DR && t_q.ir == IR_USERCODE
    |=> t_q.dr[WORD_LEN-1:0] == USER_CODE)
    else $error("user code not captured");
  a_sample_cap: assert property (t_q.st == TAP_CAP_DR && t_q.ir == IR_SAMPLE
    |=> t_q.dr == $past(t_q.cf))
    else $error("sample capture mismatch");
  a_extest_arm: assert property (t_q.st == TAP_UP_IR && t_q.irs == IR_EXTEST
    |=> t_q.act ##1 t_q.st != TAP_RESET || t_q.act)
    else $error("force instruction not armed");
  a_force_toggle: assert property (t_q.st == TAP_UP_DR && t_q.ir == IR_EXTEST
    && t_q.dr != t_q.upd |=> t_q.upd == $past(t_q.dr) && t_q.tgl != $past(t_q.tgl))
    else $error("force word not handed over");

endmodule

// ===== bst_tb.sv
// Self-checking bench for the boundary scan test port
`timescale 1ns/1ps

module tb;
  import bst_pkg::*;
  localparam bst_word_t USER_VAL = 32'h5a3c_96e1;
  logic             mclk;
  logic             rst_n;
  logic             tck;
  logic             tms;
  logic             tdi;
  logic             tdo;
  logic             tdo_oe;
  logic             t;
  logic [N_PIN-1:0] pad;
  bst_drv_s         core_drv;
  bst_drv_s         pad_drv;
  bst_rx_s          core_rx;
  logic [39:0]      got;
  int               fails = 0;
  int               checks_done = 0;

  bst_tap #(.USER_CODE(USER_VAL)) i_bst_tap
  (
    .mclk_i(mclk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pad_i(pad), .core_drv_i(core_drv),
    .pad_drv_o(pad_drv), .core_rx_o(core_rx)
  );

  bst_ctl_model i_bst_ctl_model
  (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Boundary word from per-pin values, bit 0 nearest data out
  function automatic logic [39:0] cells(input logic [11:0] oe, dat, din,
                                        input logic [3:0] gk);
    logic [39:0] c;
    int          b;
    c = '0;
    for (int p = 0; p < N_PIN; p++)
    begin
      b = (p < 8) ? 3 * p : 24 + 4 * (p - 8);
      c[b + CELL_TS] = oe[p];
      c[b + CELL_OUT] = dat[p];
      c[b + CELL_IN] = din[p];
      if (p >= 8)
        c[b + CELL_CLK] = gk[p - 8];
    end
    return c;
  endfunction

  task automatic summarize();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ident();
    i_bst_ctl_model.scan(1'b0, 40'h0, 32, got);
    cmp("id word", ID_CODE_DEF, got[31:0]);
    @(negedge mclk);
    cmp("tdo enable idle", 40'h0, tdo_oe);
    i_bst_ctl_model.scan(1'b1, IR_IDCODE, 10, got);
    cmp("ir capture", IR_CAPTURE, got[9:0]);
  endtask

  task automatic t_bypass();
    bst_ir_t codes [2] = '{IR_BYPASS, 10'h155};
    foreach (codes[k])
    begin
      i_bst_ctl_model.scan(1'b1, codes[k], 10, got);
      i_bst_ctl_model.scan(1'b0, 40'hb5, 8, got);
      cmp("bypass path", 40'h6a, got[7:0]);
    end
  endtask

  task automatic t_user();
    i_bst_ctl_model.scan(1'b1, IR_USERCODE, 10, got);
    i_bst_ctl_model.scan(1'b0, 40'h0, 32, got);
    cmp("user word", USER_VAL, got[31:0]);
  endtask

  task automatic t_sample();
    @(negedge mclk);
    pad = 12'ha5c;
    core_drv = '{oe: 12'h3c9, dat: 12'h6b2};
    repeat (10) @(negedge mclk);
    cmp("pass drive", core_drv, pad_drv);
    i_bst_ctl_model.scan(1'b1, IR_SAMPLE, 10, got);
    i_bst_ctl_model.scan(1'b0, 40'h0, 40, got);
    cmp("sample cells", cells(12'h3c9, 12'h6b2, 12'ha5c, 4'ha), got);
  endtask

  task automatic t_extest();
    logic [39:0] w;
    w = cells(12'h5e1, 12'h9a7, 12'h3b4, 4'h6);
    i_bst_ctl_model.scan(1'b1, IR_EXTEST, 10, got);
    i_bst_ctl_model.scan(1'b0, w, 40, got);
    repeat (10) @(negedge mclk);
    cmp("forced drive", {12'h5e1, 12'h9a7}, pad_drv);
    cmp("forced input", {12'h3b4, 4'h6}, core_rx);
    repeat (5) i_bst_ctl_model.tick(1'b1, 1'b0, t);
    i_bst_ctl_model.tick(1'b0, 1'b0, t);
    repeat (10) @(negedge mclk);
    cmp("released drive", core_drv, pad_drv);
    cmp("released input", pad, core_rx.dat);
    cmp("released clock", pad[11:8], core_rx.gclk);
    i_bst_ctl_model.scan(1'b0, 40'h0, 32, got);
    cmp("id after reset", ID_CODE_DEF, got[31:0]);
  endtask

  // Mid-run reset with mode select low: only the reset input can reach reset
  task automatic t_reset();
    i_bst_ctl_model.scan(1'b1, IR_USERCODE, 10, got);
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (6) i_bst_ctl_model.tick(1'b0, 1'b0, t);
    @(negedge mclk);
    cmp("drive in reset", 40'h0, pad_drv);
    cmp("input in reset", 40'h0, core_rx);
    rst_n = 1'b1;
    repeat (4) i_bst_ctl_model.tick(1'b1, 1'b0, t);
    i_bst_ctl_model.tick(1'b0, 1'b0, t);
    repeat (10) @(negedge mclk);
    cmp("drive after reset", core_drv, pad_drv);
    i_bst_ctl_model.scan(1'b0, 40'h0, 32, got);
    cmp("id after sync reset", ID_CODE_DEF, got[31:0]);
  endtask

  // ----------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial
  begin
    #3000000;
    fails++;
    summarize();
  end

  initial
  begin
    rst_n = 1'b0;
    pad = 12'h000;
    core_drv = '0;
    fork
      repeat (20) @(negedge mclk);
      repeat (8) i_bst_ctl_model.tick(1'b1, 1'b0, t);
    join
    rst_n = 1'b1;
    repeat (4) i_bst_ctl_model.tick(1'b1, 1'b0, t);
    i_bst_ctl_model.tick(1'b0, 1'b0, t);
    t_ident();
    t_bypass();
    t_user();
    t_sample();
    t_extest();
    t_reset();
    summarize();
  end
endmodule
